// *** pulse_test_pkg.sv ***
// Package of constants and carrier types for the safety input test logic
package pulse_test_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_CH = 8;
  localparam int NUM_PAIRS = NUM_CH / 2;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 250000000;
  localparam int PULSE_US = 525;
  localparam int PERIOD_MS = 144;
  localparam int DISC_STEP_MS = 10;
  localparam int PULSE_CYC = PULSE_US * (CLK_HZ / 1000000);
  localparam longint PERIOD_CYC_L = longint'(PERIOD_MS) * (CLK_HZ / 1000);
  localparam int PERIOD_CYC = int'(PERIOD_CYC_L);
  localparam int STEP_CYC = DISC_STEP_MS * (CLK_HZ / 1000);
  localparam int SETTLE_CYC = 16;
  localparam int DISC_W = 13;
  // ==========================================================
  // Test output modes
  typedef enum logic [1:0] {
    TOUT_OFF,
    TOUT_PULSE,
    TOUT_POWER
  } tout_mode_e;
  // Pair modes
  typedef enum logic [1:0] {
    PAIR_SINGLE,
    PAIR_EQUIV,
    PAIR_COMPL
  } pair_mode_e;
  // Per-channel result to the network
  typedef struct packed {
    logic [NUM_CH-1:0] data;
    logic [NUM_CH-1:0] status;
  } in_report_s;
endpackage : pulse_test_pkg

// *** pulse_gen.sv ***
// Shared test pulse timer: discrepancy step tick, sample strobe and low pulse window
`timescale 1ns/1ps
module pulse_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Timing outputs
  output logic pulse_o,
  output logic sample_o,
  output logic step_o,
  // Pulse, period and step counts
  input wire logic [31:0] pulse_i,
  input wire logic [31:0] period_i,
  input wire logic [31:0] step_i
);
  logic [31:0] cnt_r;
  logic [31:0] step_cnt_r;

  // Period counter, pulse in the first PULSE_CYC cycles
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 32'h0;
    end else if (cnt_r >= period_i - 32'h1) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // Discrepancy time base
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step_cnt_r <= 32'h0;
    end else if (step_cnt_r >= step_i - 32'h1) begin
      step_cnt_r <= 32'h0;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
    end
  end

  // Pulse window; sample near its end after lines settle
  assign pulse_o = (cnt_r < pulse_i);
  assign sample_o = (cnt_r == pulse_i - 32'h1);
  assign step_o = (step_cnt_r == 32'h0);
endmodule : pulse_gen

// *** safety_input_pulse_test.sv ***
// Safety digital inputs with pulse test, fault latching and pair checks
`timescale 1ns/1ps
module safety_input_pulse_test #(
  parameter int PULSE_CYC = pulse_test_pkg::PULSE_CYC,
  parameter int PERIOD_CYC = pulse_test_pkg::PERIOD_CYC,
  parameter int STEP_CYC = pulse_test_pkg::STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Field pins
  input wire logic [pulse_test_pkg::NUM_CH-1:0] in_pin_i,
  output logic [pulse_test_pkg::NUM_CH-1:0] tout_o,
  // Configuration
  input wire pulse_test_pkg::tout_mode_e [pulse_test_pkg::NUM_CH-1:0]
    tout_mode_i,
  input wire logic [pulse_test_pkg::NUM_CH-1:0][2:0] tout_sel_i,
  input wire pulse_test_pkg::pair_mode_e [pulse_test_pkg::NUM_PAIRS-1:0]
    pair_mode_i,
  input wire logic [pulse_test_pkg::DISC_W-1:0] disc_steps_i,
  input wire logic fault_clear_i,
  // Report to controller
  output pulse_test_pkg::in_report_s report_o,
  output logic [pulse_test_pkg::NUM_CH-1:0] wire_fault_o,
  output logic [pulse_test_pkg::NUM_PAIRS-1:0] disc_fault_o
);
  localparam int N = pulse_test_pkg::NUM_CH;
  localparam int P = pulse_test_pkg::NUM_PAIRS;

  // ==========================================================
  // Input synchronisers
  logic [N-1:0] meta_r;
  logic [N-1:0] in_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      in_r <= '0;
    end else begin
      meta_r <= in_pin_i;
      in_r <= meta_r;
    end
  end

  // ==========================================================
  // Pulse timer
  logic pulse;
  logic sample;
  logic step;
  pulse_gen u_gen (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pulse_o(pulse),
    .sample_o(sample),
    .step_o(step),
    .pulse_i(32'(PULSE_CYC)),
    .period_i(32'(PERIOD_CYC)),
    .step_i(32'(STEP_CYC))
  );

  // Test source for each input: index of its test output
  function automatic logic [2:0] src_of(input logic [N-1:0][2:0] sel,
                                        input int ch);
    src_of = sel[ch];
  endfunction : src_of

  // Which outputs pulse: pulse source with its tied input closed.
  // A passing pulse pulls a healthy input low, so a source that started
  // pulsing keeps going until the window ends instead of chattering.
  logic [N-1:0] pulsing;
  logic [N-1:0] pulsing_r;
  always_comb begin
    pulsing = '0;
    for (int t = 0; t < N; t++) begin
      if (tout_mode_i[t] == pulse_test_pkg::TOUT_PULSE) begin
        pulsing[t] = in_r[t] || (pulse && pulsing_r[t]);
      end
    end
  end

  // Pulsing memory, kept only inside the window
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulsing_r <= '0;
    end else begin
      pulsing_r <= pulse ? pulsing : '0;
    end
  end

  // ==========================================================
  // Test outputs: pulse mode high, dropping low for the pulse window while the output is pulsing; power mode high, off mode low
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tout_o <= '0;
    end else begin
      for (int t = 0; t < N; t++) begin
        unique case (tout_mode_i[t])
          pulse_test_pkg::TOUT_PULSE: begin
            tout_o[t] <= !(pulse && pulsing[t]);
          end
          pulse_test_pkg::TOUT_POWER: tout_o[t] <= 1'b1;
          default: tout_o[t] <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Wiring check: during the pulse, an input fed by a pulsing source
  // must read low; staying high means short to supply or cross short.
  // An open wire simply reads low, so its data stays off on its own, except on the odd input of a complementary pair, whose safe state reports 1.
  logic [N-1:0] wfault_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wfault_r <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        logic [2:0] s;
        s = src_of(tout_sel_i, c);
        if (sample && pulsing[s] && in_r[c]) begin
          wfault_r[c] <= 1'b1;
        end else if (fault_clear_i && !in_r[c]) begin
          wfault_r[c] <= 1'b0;
        end
      end
    end
  end
  assign wire_fault_o = wfault_r;

  // ==========================================================
  // Pair discrepancy timers on even/odd pairs
  logic [P-1:0][pulse_test_pkg::DISC_W-1:0] disc_cnt_r;
  logic [P-1:0] dfault_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disc_cnt_r <= '0;
      dfault_r <= '0;
    end else begin
      for (int p = 0; p < P; p++) begin
        logic a;
        logic b;
        logic bad;
        a = in_r[2*p];
        b = in_r[2*p+1];
        bad = 1'b0;
        if (pair_mode_i[p] == pulse_test_pkg::PAIR_EQUIV) begin
          bad = (a != b);
        end else if (pair_mode_i[p] == pulse_test_pkg::PAIR_COMPL) begin
          bad = (a == b);
        end
        if (!bad) begin
          disc_cnt_r[p] <= '0;
          if (fault_clear_i && !dfault_r[p]) begin
            dfault_r[p] <= 1'b0;
          end else if (fault_clear_i && !a) begin
            dfault_r[p] <= 1'b0;
          end
        end else if (disc_cnt_r[p] >= disc_steps_i) begin
          dfault_r[p] <= 1'b1;
        end else if (step) begin
          disc_cnt_r[p] <= disc_cnt_r[p] + 1'b1;
        end
      end
    end
  end
  assign disc_fault_o = dfault_r;

  // ==========================================================
  // Report: live values or safe state per channel
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      report_o <= '0;
    end else begin
      for (int p = 0; p < P; p++) begin
        logic e;
        logic o;
        e = in_r[2*p];
        o = in_r[2*p+1];
        unique case (pair_mode_i[p])
          pulse_test_pkg::PAIR_EQUIV: begin
            if (dfault_r[p] || wfault_r[2*p] || wfault_r[2*p+1]) begin
              report_o.data[2*p] <= 1'b0;
              report_o.data[2*p+1] <= 1'b0;
              report_o.status[2*p] <= 1'b0;
              report_o.status[2*p+1] <= 1'b0;
            end else begin
              report_o.data[2*p] <= e & o;
              report_o.data[2*p+1] <= e & o;
              report_o.status[2*p] <= (e == o);
              report_o.status[2*p+1] <= (e == o);
            end
          end
          pulse_test_pkg::PAIR_COMPL: begin
            if (dfault_r[p] || wfault_r[2*p] || wfault_r[2*p+1]
                || (e == o)) begin
              report_o.data[2*p] <= 1'b0;
              report_o.data[2*p+1] <= 1'b1;
              report_o.status[2*p] <= 1'b0;
              report_o.status[2*p+1] <= 1'b0;
            end else begin
              report_o.data[2*p] <= e;
              report_o.data[2*p+1] <= o;
              report_o.status[2*p] <= 1'b1;
              report_o.status[2*p+1] <= 1'b1;
            end
          end
          default: begin
            for (int k = 0; k < 2; k++) begin
              report_o.data[2*p+k] <= in_r[2*p+k] && !wfault_r[2*p+k];
              report_o.status[2*p+k] <= !wfault_r[2*p+k];
            end
          end
        endcase
      end
    end
  end
endmodule : safety_input_pulse_test

// *** field_contacts.sv ***
// Field contact model between test outputs and safety inputs
`timescale 1ns/1ps
module field_contacts (
  // Test output sources
  input wire logic [7:0] tout_i,
  // Contact and wiring state
  input wire logic [7:0] closed_i,
  input wire logic [7:0] short_i,
  // Safety input pins, pulled low when open
  output logic [7:0] in_pin_o
);
  // Closed contact passes its source, a short holds the pin high
  assign in_pin_o = short_i | (closed_i & tout_i);
endmodule : field_contacts

// *** safety_input_pulse_test_properties.sv ***
// Port checker for the safety input test logic
`timescale 1ns/1ps
module pulse_test_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Watched ports
  input wire logic [7:0] in_pin_i,
  input wire logic [7:0] tout_o,
  input wire pulse_test_pkg::tout_mode_e [7:0] tout_mode_i,
  input wire pulse_test_pkg::pair_mode_e [3:0] pair_mode_i,
  input wire logic fault_clear_i,
  input wire pulse_test_pkg::in_report_s report_o,
  input wire logic [7:0] wire_fault_o,
  input wire logic [3:0] disc_fault_o
);
  // ========================================
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_power_level: assert property (
    (tout_mode_i[2] == pulse_test_pkg::TOUT_POWER) [*3] |-> tout_o[2])
    else $error("power output low");
  chk_off_level: assert property (
    (tout_mode_i[7] == pulse_test_pkg::TOUT_OFF) [*3] |-> !tout_o[7])
    else $error("off output high");
  chk_open_no_pulse: assert property (
    (tout_mode_i[1] == pulse_test_pkg::TOUT_PULSE && !in_pin_i[1]) [*4]
    ##0 tout_o[1] |=> tout_o[1]) else $error("pulse with open contact");
  chk_open_data: assert property (
    (!in_pin_i[0]) [*4] |-> !report_o.data[0])
    else $error("open input reads on");
  chk_single_fault: assert property (
    $past(wire_fault_o[0]) |-> !report_o.data[0] && !report_o.status[0])
    else $error("faulted input not off");
  chk_wire_latch: assert property (
    wire_fault_o[0] && !fault_clear_i |=> wire_fault_o[0])
    else $error("wire fault dropped");
  chk_equiv_off: assert property (
    $past(disc_fault_o[1]) && pair_mode_i[1] == pulse_test_pkg::PAIR_EQUIV
    |-> {report_o.data[3:2], report_o.status[3:2]} == 4'h0)
    else $error("equivalent pair not off");
  chk_compl_safe: assert property (
    $past(disc_fault_o[2]) && pair_mode_i[2] == pulse_test_pkg::PAIR_COMPL
    |-> {report_o.data[5:4], report_o.status[5:4]} == 4'h8)
    else $error("complementary safe state wrong");
endmodule : pulse_test_checker

bind safety_input_pulse_test pulse_test_checker u_chk (.clk_i(clk_i),
  .resetn_i(resetn_i), .in_pin_i(in_pin_i), .tout_o(tout_o),
  .tout_mode_i(tout_mode_i), .pair_mode_i(pair_mode_i),
  .fault_clear_i(fault_clear_i), .report_o(report_o),
  .wire_fault_o(wire_fault_o), .disc_fault_o(disc_fault_o));

// *** safety_input_pulse_test_bench.sv ***
// Self-checking bench for the safety input test logic
`timescale 1ns/1ps
module safety_input_pulse_test_bench;
  // ========================================
  // Signals
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic fault_clear = 1'b0;
  logic [7:0] closed = 8'h00;
  logic [7:0] shorted = 8'h00;
  logic [7:0] in_pin;
  logic [7:0] tout;
  logic [7:0][2:0] sel = 24'hfac688;
  logic [12:0] disc_steps = 13'h0002;
  pulse_test_pkg::tout_mode_e [7:0] tmode =
    '{default: pulse_test_pkg::TOUT_OFF};
  pulse_test_pkg::pair_mode_e [3:0] pmode =
    '{default: pulse_test_pkg::PAIR_SINGLE};
  pulse_test_pkg::in_report_s rep;
  logic [7:0] wire_fault;
  logic [3:0] disc_fault;
  int miscompares = 0;
  int cmp_count = 0;
  // Clock
  always #2 clk_i = ~clk_i;
  // ========================================
  // Block and field
  safety_input_pulse_test #(.PULSE_CYC(200), .PERIOD_CYC(1000),
    .STEP_CYC(50)) DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .in_pin_i(in_pin), .tout_o(tout),
    .tout_mode_i(tmode), .tout_sel_i(sel), .pair_mode_i(pmode),
    .disc_steps_i(disc_steps), .fault_clear_i(fault_clear),
    .report_o(rep), .wire_fault_o(wire_fault), .disc_fault_o(disc_fault));
  field_contacts u_field (.tout_i(tout), .closed_i(closed),
    .short_i(shorted), .in_pin_o(in_pin));
  // ========================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] got,
      input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // ========================================
  // Scenarios
  // Shorted input under pulse test, healthy closed input beside it
  task automatic t_pulse();
    tmode[0] <= pulse_test_pkg::TOUT_PULSE;
    tmode[1] <= pulse_test_pkg::TOUT_PULSE;
    closed <= 8'h03;
    shorted <= 8'h01;
    cyc(20);
    chk("pulse start", tout[1:0], 16'h0);
    cyc(180);
    chk("pulse end", tout[1:0], 16'h0);
    cyc(2);
    chk("pulse gap", tout[1:0], 16'h3);
    cyc(68);
    chk("wire fault", wire_fault, 16'h1);
    chk("fault off", {rep.data[1:0], rep.status[1:0]}, 16'ha);
    shorted <= 8'h00;
    closed <= 8'h00;
    fault_clear <= 1'b1;
    cyc(10);
    chk("fault clear", wire_fault, 16'h0);
    fault_clear <= 1'b0;
  endtask : t_pulse
  // Equivalent, complementary and single pairs side by side
  task automatic t_pairs();
    for (int i = 2; i < 8; i++) tmode[i] <= pulse_test_pkg::TOUT_POWER;
    pmode[1] <= pulse_test_pkg::PAIR_EQUIV;
    pmode[2] <= pulse_test_pkg::PAIR_COMPL;
    closed <= 8'h74;
    cyc(20);
    chk("power", tout[7:2], 16'h3f);
    chk("early disc", disc_fault, 16'h0);
    chk("compl now", {rep.data[5:4], rep.status[5:4]}, 16'h8);
    cyc(400);
    chk("disc", disc_fault, 16'h6);
    chk("equiv", {rep.data[3:2], rep.status[3:2]}, 16'h0);
    chk("compl", {rep.data[5:4], rep.status[5:4]}, 16'h8);
    chk("single", {rep.data[7:6], rep.status[7:6]}, 16'h7);
  endtask : t_pairs
  // ========================================
  // Main sequence and hang guard
  initial begin
    cyc(5);
    resetn_i <= 1'b1;
    t_pulse();
    t_pairs();
    wrap_up();
  end
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule : safety_input_pulse_test_bench
